// ### bench/pci_dev_model.sv
/*
 * Target-side model of the network controller's bus interface.
 * Assumes command bit 0 marks a write and pull-ups sit outside.
 */
`timescale 1ns/10ps
`default_nettype none

module pci_dev_model (
    // Clock, reset and test knobs
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        no_claim,
    input wire logic        bad_par,
    input wire logic [3:0]  wait_cyc,
    // Resolved bus lines
    input wire logic        frame_n,
    input wire logic        irdy_n,
    input wire logic [31:0] ad,
    input wire logic [3:0]  cbe,
    input wire logic        par,
    // Target drive
    output var logic        trdy_n,
    output var logic        devsel_n,
    output var logic        perr_n,
    output var logic [31:0] m_ad,
    output var logic        m_ad_oe,
    output var logic        m_par,
    output var logic        m_par_oe
);
    logic        act, wr, pchk, pv, xfer;
    logic [31:0] addr;
    logic [7:0]  idx;
    logic [3:0]  wcnt, last_be;
    logic [31:0] wr_log [0:7];
    int          perr_cnt;

    assign xfer = act && !irdy_n && !trdy_n;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            act <= 1'b0;
            trdy_n <= 1'b1;
            devsel_n <= 1'b1;
            perr_n <= 1'b1;
            m_ad_oe <= 1'b0;
            m_par_oe <= 1'b0;
            pchk <= 1'b0;
            perr_cnt <= 0;
        end else begin
            pv <= ^{ad, cbe};
            pchk <= (!act && !frame_n) || (xfer && wr);
            perr_n <= !(pchk && (par != (pv ^ bad_par)));
            if (pchk && (par != (pv ^ bad_par))) perr_cnt <= perr_cnt + 1;
            m_par <= ^{m_ad, cbe} ^ bad_par;
            m_par_oe <= m_ad_oe;
            if (!act && !frame_n) begin
                act <= 1'b1;
                wr <= cbe[0];
                addr <= ad;
                idx <= 8'h00;
                wcnt <= wait_cyc;
                devsel_n <= no_claim;
            end else if (act) begin
                if (xfer) begin
                    if (wr) wr_log[idx[2:0]] <= ad;
                    last_be <= cbe;
                    idx <= idx + 8'h01;
                    trdy_n <= 1'b1;
                    wcnt <= wait_cyc;
                    if (frame_n) begin
                        act <= 1'b0;
                        devsel_n <= 1'b1;
                        m_ad_oe <= 1'b0;
                    end
                end else if (frame_n && irdy_n) begin
                    act <= 1'b0;
                end else if (!no_claim && trdy_n) begin
                    if (wcnt != 4'h0) wcnt <= wcnt - 4'h1;
                    else begin
                        // Drive only after the address clock: turnaround
                        trdy_n <= 1'b0;
                        m_ad <= ~(addr + {idx, 2'b00});
                        m_ad_oe <= !wr;
                    end
                end
            end
        end
    end
endmodule

`default_nettype wire

// ### bench/pci_host_asserts.sv
/*
 * Pin-level checker for the bus initiator.
 * Assumes it is bound into pci_host and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none

module pci_host_asserts (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        resetn,
    // User side
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_write,
    input wire logic [3:0]  req_cmd,
    input wire logic [31:0] req_addr,
    input wire logic        rd_valid,
    input wire logic [31:0] rd_data,
    input wire logic        done,
    input wire logic        master_abort,
    input wire logic        par_err,
    // Bus pins
    input wire logic        gnt_n,
    input wire logic        frame_n_i,
    input wire logic        frame_n_o,
    input wire logic        frame_n_oe,
    input wire logic        irdy_n_i,
    input wire logic        irdy_n_o,
    input wire logic        irdy_n_oe,
    input wire logic        trdy_n_i,
    input wire logic        devsel_n_i,
    input wire logic [31:0] ad_i,
    input wire logic [31:0] ad_o,
    input wire logic        ad_oe,
    input wire logic [3:0]  cbe_o,
    input wire logic        cbe_oe,
    input wire logic        par_i,
    input wire logic        par_o,
    input wire logic        par_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic wr_ff, nxt_wr, rd_xfer;

    always_comb nxt_wr = (req_valid && req_ready) ? req_write : wr_ff;
    always_ff @(posedge sys_clk) wr_ff <= resetn ? nxt_wr : 1'b0;
    assign rd_xfer = !wr_ff && irdy_n_oe && !irdy_n_o && !trdy_n_i;

    ////////////////////////////////////////////////////////////////
    AST_FLOAT_RST: assert property (disable iff (1'b0)
        !resetn |=> !(frame_n_oe || irdy_n_oe || ad_oe || cbe_oe || par_oe))
        else $error("bus driven after reset");
    AST_FRAME_PARK: assert property (
        $fell(frame_n_oe) |-> $past(frame_n_o)) else $error("frame floated low");
    AST_IRDY_PARK: assert property (
        $fell(irdy_n_oe) |-> $past(irdy_n_o)) else $error("irdy floated low");
    AST_START_IDLE: assert property (
        req_ready |-> !gnt_n && frame_n_i && irdy_n_i && $past(frame_n_i) && $past(irdy_n_i))
        else $error("start on busy bus");
    AST_ADDR_PHASE: assert property (
        req_valid && req_ready |=> frame_n_oe && !frame_n_o && cbe_oe
        && cbe_o == $past(req_cmd) && ad_o == $past(req_addr)) else $error("bad address phase");
    AST_AD_DIR: assert property (
        irdy_n_oe && !irdy_n_o |-> ad_oe == wr_ff) else $error("wrong data direction");
    AST_BE_HOLD: assert property (
        $past(cbe_oe, 2) && $past(cbe_oe) && cbe_oe |-> $stable(cbe_o))
        else $error("byte enables moved");
    AST_PAR_CALC: assert property (
        par_oe |-> par_o == ^{$past(ad_o), $past(cbe_o)}) else $error("bad parity");
    AST_PAR_OWN: assert property (
        par_oe == $past(ad_oe)) else $error("parity owner wrong");
    AST_RD_XFER: assert property (
        rd_xfer |=> rd_valid && rd_data == $past(ad_i)) else $error("read not taken");
    AST_RD_PAR: assert property (
        rd_xfer ##1 (par_i != ^{$past(ad_i), $past(cbe_o)}) |=> par_err)
        else $error("parity error missed");
    AST_ABORT: assert property (
        $fell(frame_n_o) ##1 devsel_n_i [*6] |=> master_abort) else $error("no abort");
    AST_DONE_FLOAT: assert property (
        done |-> !(frame_n_oe || irdy_n_oe || ad_oe || cbe_oe || par_oe))
        else $error("bus held at done");
endmodule

bind pci_host pci_host_asserts chk_u (.*);

`default_nettype wire

// ### bench/tb_top.sv
/*
 * Self-checking bench for the bus initiator against the target model.
 * Assumes the design and checker files are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top;
    logic sys_clk = 1'b0, resetn = 1'b0, gnt_n = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, wr_valid = 1'b0;
    logic [3:0] req_cmd = 4'h0, req_be = 4'h0, wait_cyc = 4'h0;
    logic [31:0] req_addr = 32'h0, wr_data = 32'h0;
    logic [7:0] req_len = 8'h00;
    logic no_claim = 1'b0, bad_par = 1'b0;
    logic req_ready, wr_ready, rd_valid, done, master_abort, par_err, perr_seen;
    logic frame_n_o, frame_n_oe, irdy_n_o, irdy_n_oe, ad_oe, cbe_oe, par_o, par_oe;
    logic [31:0] rd_data, ad_o, m_ad, ad_w;
    logic [3:0] cbe_o, cbe_w;
    logic trdy_n, devsel_n, perr_n, m_ad_oe, m_par, m_par_oe;
    logic frame_w, irdy_w, par_w;
    logic [36:0] lastv = 37'h0;
    logic [31:0] rdq [$];
    int miscompares = 0, check_count = 0, ab, pe, ps;

    always #2 sys_clk = ~sys_clk;

    // Pull-ups on frame and irdy; AD, enables and parity show the inverse when floating
    assign frame_w = frame_n_oe ? frame_n_o : 1'b1;
    assign irdy_w = irdy_n_oe ? irdy_n_o : 1'b1;
    assign ad_w = ad_oe ? ad_o : (m_ad_oe ? m_ad : ~lastv[31:0]);
    assign cbe_w = cbe_oe ? cbe_o : ~lastv[35:32];
    assign par_w = par_oe ? par_o : (m_par_oe ? m_par : ~lastv[36]);
    always @(posedge sys_clk) lastv <= {par_w, cbe_w, ad_w};

    pci_host dut_u (.*, .frame_n_i(frame_w), .irdy_n_i(irdy_w), .trdy_n_i(trdy_n),
        .devsel_n_i(devsel_n), .perr_n_i(perr_n), .ad_i(ad_w), .par_i(par_w));
    pci_dev_model dev_u (.sys_clk, .resetn, .no_claim, .bad_par, .wait_cyc,
        .frame_n(frame_w), .irdy_n(irdy_w), .ad(ad_w), .cbe(cbe_w), .par(par_w),
        .trdy_n, .devsel_n, .perr_n, .m_ad, .m_ad_oe, .m_par, .m_par_oe);

    ////////////////////////////////////////////////////////////////
    task automatic start(input logic w, input logic [31:0] a, input logic [7:0] n,
                         input logic [3:0] be, input logic hold);
        int k;
        rdq.delete();
        ab = 0;
        pe = 0;
        ps = 0;
        gnt_n = hold;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = w;
        req_cmd = w ? 4'h7 : 4'h6;
        req_addr = a;
        req_len = n;
        req_be = be;
        for (k = 0; k < 4 && hold; k++) begin
            @(negedge sys_clk);
            `CHK(frame_n_oe, 1'b0)
        end
        gnt_n = 1'b0;
        #1;
        for (k = 0; k < 40 && !req_ready; k++) @(negedge sys_clk);
        `CHK(req_ready, 1'b1)
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (k = 0; k < 100; k++) begin
            @(negedge sys_clk);
            if (rd_valid) rdq.push_back(rd_data);
            ab += int'(master_abort);
            pe += int'(par_err);
            ps += int'(perr_seen);
            if (done) break;
        end
        `CHK(done, 1'b1)
    endtask

    task automatic t_write;
        int i;
        wait_cyc = 4'h2;
        for (i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            wr_valid = 1'b1;
            wr_data = 32'ha5a50000 + i;
            `CHK(wr_ready, 1'b1)
        end
        @(negedge sys_clk);
        `CHK(wr_ready, 1'b0)
        wr_valid = 1'b0;
        start(1'b1, 32'h00000100, 8'h08, 4'h5, 1'b1);
        for (i = 0; i < 8; i++) `CHK(dev_u.wr_log[i], 32'ha5a50000 + i)
        `CHK(dev_u.last_be, 4'h5)
        `CHK(dev_u.perr_cnt, 0)
        `CHK(wr_ready, 1'b1)
    endtask

    task automatic t_read;
        int j, k;
        for (j = 0; j < 2; j++) begin
            wait_cyc = j[3:0];
            start(1'b0, 32'h00001000, j ? 8'h03 : 8'h00, 4'hc, 1'b0);
            `CHK(rdq.size(), j ? 3 : 1)
            for (k = 0; k < rdq.size(); k++) `CHK(rdq[k], ~(32'h00001000 + 4 * k))
            `CHK(pe, 0)
        end
    endtask

    task automatic t_abort;
        no_claim = 1'b1;
        start(1'b0, 32'h00002000, 8'h01, 4'hf, 1'b0);
        no_claim = 1'b0;
        `CHK(ab, 1)
        `CHK(rdq.size(), 0)
    endtask

    task automatic t_badpar;
        int p0;
        p0 = dev_u.perr_cnt;
        bad_par = 1'b1;
        start(1'b0, 32'h00003000, 8'h01, 4'h3, 1'b0);
        bad_par = 1'b0;
        `CHK(pe, 1)
        `CHK(ps, 1)
        `CHK(dev_u.perr_cnt, p0 + 1)
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #20000;
        miscompares++;
        tally_and_finish;
    end

    initial begin
        repeat (10) @(negedge sys_clk);
        `CHK({frame_n_oe, irdy_n_oe, ad_oe, cbe_oe, par_oe}, 5'h00)
        resetn = 1'b1;
        t_write;
        t_read;
        t_abort;
        t_badpar;
        tally_and_finish;
    end
endmodule

`default_nettype wire

// ### verilog/pci_host.sv
/*
 * Bus initiator that drives the network controller as a target: address
 * phase, burst of data phases, turnaround, parity generation and checking.
 * Assumes the device's bus clock is sys_clk and that the arbiter grant and
 * all bus inputs are launched on that same clock; pull-ups are external.
 */
// Operation
// [R1] Drive line high one clock before floating
// [R2] Start driving one clock after release
// [R3] Active-low lines, single owner each
// [R4] Device only pulls open-drain lines low
// [R5] Initiator drives address; writes keep, reads release
// [R6] Target samples address, drives read data
// [R7] Non-participant floats all shared bus lines
// [R8] Launch and sample on rising edge only
// [R9] Command in address, byte enables in data
// [R10] Enable bit 0 is lowest byte lane
// [R11] Device drives enables only as initiator
// [R12] Parity even over address/data and enables
// [R13] Parity lags address/data by one clock
// [R14] Parity driven by whoever drives data
// [R15] Device reports parity mismatch on error line
// [R16] Frame held until final data phase
// [R17] Device drives frame only as initiator
// [R18] Transfer only when both readies asserted
// [R19] Initiator ready only with data or room
// [R20] Device drives initiator ready as initiator
// [R21] Abort if no select in six clocks
// [R22] Target ready only with data or room
// [R23] Wait for frame release before starting
// [R24] Float all bus outputs during reset
`timescale 1ns/10ps
`default_nettype none

module pci_host #(
    parameter int AD_W       = pci_host_pkg::AD_W,
    parameter int CBE_W      = pci_host_pkg::CBE_W,
    parameter int LEN_W      = pci_host_pkg::LEN_W,
    parameter int FIFO_DEPTH = pci_host_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Transaction request
    input  wire logic             req_valid,
    output logic                  req_ready,
    input  wire logic             req_write,
    input  wire logic [CBE_W-1:0] req_cmd,
    input  wire logic [AD_W-1:0]  req_addr,
    input  wire logic [CBE_W-1:0] req_be,
    input  wire logic [LEN_W-1:0] req_len,
    // Write data stream
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [AD_W-1:0]  wr_data,
    // Read data and status
    output logic                  rd_valid,
    output logic [AD_W-1:0]       rd_data,
    output logic                  done,
    output logic                  master_abort,
    output logic                  par_err,
    output logic                  perr_seen,
    // Bus pins
    input  wire logic             gnt_n,
    input  wire logic             frame_n_i,
    output logic                  frame_n_o,
    output logic                  frame_n_oe,
    input  wire logic             irdy_n_i,
    output logic                  irdy_n_o,
    output logic                  irdy_n_oe,
    input  wire logic             trdy_n_i,
    input  wire logic             devsel_n_i,
    input  wire logic             perr_n_i,
    input  wire logic [AD_W-1:0]  ad_i,
    output logic [AD_W-1:0]       ad_o,
    output logic                  ad_oe,
    output logic [CBE_W-1:0]      cbe_o,
    output logic                  cbe_oe,
    input  wire logic             par_i,
    output logic                  par_o,
    output logic                  par_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Write data buffer

    logic            fifo_valid;
    logic            fifo_pop;
    logic [AD_W-1:0] fifo_data;

    wr_fifo #(
        .W     (AD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transaction sequencer

    pci_host_pkg::state_t st_ff, nxt_st;

    logic             frame_ff, nxt_frame, frame_oe_ff, nxt_frame_oe;
    logic             irdy_ff, nxt_irdy, irdy_oe_ff, nxt_irdy_oe;
    logic [AD_W-1:0]  ad_ff, nxt_ad;
    logic             ad_oe_ff, nxt_ad_oe;
    logic [CBE_W-1:0] cbe_ff, nxt_cbe;
    logic             cbe_oe_ff, nxt_cbe_oe;
    logic             write_ff, nxt_write;
    logic [CBE_W-1:0] be_ff, nxt_be;
    logic [LEN_W-1:0] rem_ff, nxt_rem;
    logic [pci_host_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    logic             claimed_ff, nxt_claimed;
    logic             idle_ff, nxt_idle;
    logic             done_ff, nxt_done, abort_ff, nxt_abort;
    logic             rd_valid_ff, nxt_rd_valid;
    logic [AD_W-1:0]  rd_data_ff, nxt_rd_data;
    logic             bus_idle, xfer, start;
    assign bus_idle  = (frame_n_i == pci_host_pkg::SIG_OFF) && (irdy_n_i == pci_host_pkg::SIG_OFF);
    // Previous owner released for a full clock before we grab the lines
    assign start     = (st_ff == pci_host_pkg::ST_IDLE) && req_valid && !gnt_n
                       && bus_idle && idle_ff; // [R2] [R23]
    assign req_ready = start;
    // Completion needs both readies on the same edge
    assign xfer      = (st_ff == pci_host_pkg::ST_DATA) && (irdy_ff == pci_host_pkg::SIG_ON)
                       && (trdy_n_i == pci_host_pkg::SIG_ON); // [R18]
    // Pop only when the slot on AD is free for the next word
    assign fifo_pop  = write_ff && fifo_valid && ((st_ff == pci_host_pkg::ST_ADDR)
                       || ((st_ff == pci_host_pkg::ST_DATA) && (irdy_ff == pci_host_pkg::SIG_OFF))
                       || (xfer && rem_ff != pci_host_pkg::LEN_ONE));

    always_comb begin
        nxt_st       = st_ff;
        nxt_frame    = frame_ff;
        nxt_frame_oe = frame_oe_ff;
        nxt_irdy     = irdy_ff;
        nxt_irdy_oe  = irdy_oe_ff;
        nxt_ad       = ad_ff;
        nxt_ad_oe    = ad_oe_ff;
        nxt_cbe      = cbe_ff;
        nxt_cbe_oe   = cbe_oe_ff;
        nxt_write    = write_ff;
        nxt_be       = be_ff;
        nxt_rem      = rem_ff;
        nxt_cnt      = cnt_ff;
        nxt_claimed  = claimed_ff;
        nxt_idle     = bus_idle;
        nxt_done     = 1'b0;
        nxt_abort    = 1'b0;
        nxt_rd_valid = 1'b0;
        nxt_rd_data  = rd_data_ff;
        case (st_ff)
            pci_host_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_st       = pci_host_pkg::ST_ADDR;
                    nxt_frame    = pci_host_pkg::SIG_ON; // [R16] [R3]
                    nxt_frame_oe = 1'b1; // [R17]
                    nxt_irdy     = pci_host_pkg::SIG_OFF;
                    nxt_irdy_oe  = 1'b1; // [R20]
                    nxt_ad       = req_addr; // [R5]
                    nxt_ad_oe    = 1'b1;
                    nxt_cbe      = req_cmd; // [R9]
                    nxt_cbe_oe   = 1'b1; // [R11]
                    nxt_write    = req_write;
                    nxt_be       = req_be;
                    nxt_rem      = (req_len == '0) ? pci_host_pkg::LEN_ONE : req_len;
                    nxt_claimed  = 1'b0;
                end
            end
            pci_host_pkg::ST_ADDR: begin
                nxt_st  = pci_host_pkg::ST_DATA;
                nxt_cnt = pci_host_pkg::CNT_START;
                nxt_cbe = be_ff; // [R9] [R10]
                if (write_ff) begin
                    // Ready only with a word on AD
                    if (fifo_valid) begin
                        nxt_ad   = fifo_data;
                        nxt_irdy = pci_host_pkg::SIG_ON; // [R19]
                    end
                end else begin
                    nxt_ad_oe = 1'b0; // [R5]
                    nxt_irdy  = pci_host_pkg::SIG_ON; // [R19]
                end
                if (nxt_irdy == pci_host_pkg::SIG_ON && rem_ff == pci_host_pkg::LEN_ONE) begin
                    nxt_frame = pci_host_pkg::SIG_OFF; // [R16]
                end
            end
            pci_host_pkg::ST_DATA: begin
                if (devsel_n_i == pci_host_pkg::SIG_ON) begin
                    nxt_claimed = 1'b1;
                end else if (!claimed_ff && cnt_ff != pci_host_pkg::DEVSEL_LIMIT) begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
                if (!claimed_ff && devsel_n_i == pci_host_pkg::SIG_OFF
                        && cnt_ff == pci_host_pkg::DEVSEL_LIMIT) begin
                    // No target answered: end the cycle ourselves
                    nxt_st     = pci_host_pkg::ST_TURN; // [R21]
                    nxt_abort  = 1'b1;
                    nxt_frame  = pci_host_pkg::SIG_OFF; // [R1]
                    nxt_irdy   = pci_host_pkg::SIG_OFF; // [R1]
                    nxt_ad_oe  = 1'b0;
                    nxt_cbe_oe = 1'b0;
                end else if (xfer) begin
                    if (!write_ff) begin
                        nxt_rd_valid = 1'b1;
                        nxt_rd_data  = ad_i; // [R6] [R22]
                    end
                    if (rem_ff == pci_host_pkg::LEN_ONE) begin
                        nxt_st     = pci_host_pkg::ST_TURN;
                        nxt_irdy   = pci_host_pkg::SIG_OFF; // [R1]
                        nxt_ad_oe  = 1'b0;
                        nxt_cbe_oe = 1'b0;
                    end else begin
                        nxt_rem = rem_ff - 1'b1;
                        if (write_ff) begin
                            nxt_ad   = fifo_data;
                            nxt_irdy = fifo_valid ? pci_host_pkg::SIG_ON : pci_host_pkg::SIG_OFF;
                        end
                    end
                end else if (write_ff && irdy_ff == pci_host_pkg::SIG_OFF && fifo_valid) begin
                    nxt_ad   = fifo_data;
                    nxt_irdy = pci_host_pkg::SIG_ON; // [R19]
                end
                if (nxt_st == pci_host_pkg::ST_DATA && nxt_irdy == pci_host_pkg::SIG_ON
                        && nxt_rem == pci_host_pkg::LEN_ONE) begin
                    nxt_frame = pci_host_pkg::SIG_OFF; // [R16]
                end
            end
            pci_host_pkg::ST_TURN: begin
                // Lines were driven high last clock, now let the pull-ups hold them
                nxt_st       = pci_host_pkg::ST_IDLE;
                nxt_frame_oe = 1'b0; // [R1] [R7]
                nxt_irdy_oe  = 1'b0; // [R1] [R7]
                nxt_done     = 1'b1;
            end
            default: begin
                nxt_st = pci_host_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin // [R8]
        if (!resetn) begin
            st_ff       <= pci_host_pkg::ST_IDLE;
            frame_ff    <= pci_host_pkg::SIG_OFF;
            frame_oe_ff <= 1'b0; // [R24]
            irdy_ff     <= pci_host_pkg::SIG_OFF;
            irdy_oe_ff  <= 1'b0; // [R24]
            ad_ff       <= '0;
            ad_oe_ff    <= 1'b0; // [R24]
            cbe_ff      <= '0;
            cbe_oe_ff   <= 1'b0; // [R24]
            write_ff    <= 1'b0;
            be_ff       <= '0;
            rem_ff      <= '0;
            cnt_ff      <= '0;
            claimed_ff  <= 1'b0;
            idle_ff     <= 1'b0;
            done_ff     <= 1'b0;
            abort_ff    <= 1'b0;
            rd_valid_ff <= 1'b0;
            rd_data_ff  <= '0;
        end else begin
            st_ff       <= nxt_st;
            frame_ff    <= nxt_frame;
            frame_oe_ff <= nxt_frame_oe;
            irdy_ff     <= nxt_irdy;
            irdy_oe_ff  <= nxt_irdy_oe;
            ad_ff       <= nxt_ad;
            ad_oe_ff    <= nxt_ad_oe;
            cbe_ff      <= nxt_cbe;
            cbe_oe_ff   <= nxt_cbe_oe;
            write_ff    <= nxt_write;
            be_ff       <= nxt_be;
            rem_ff      <= nxt_rem;
            cnt_ff      <= nxt_cnt;
            claimed_ff  <= nxt_claimed;
            idle_ff     <= nxt_idle;
            done_ff     <= nxt_done;
            abort_ff    <= nxt_abort;
            rd_valid_ff <= nxt_rd_valid;
            rd_data_ff  <= nxt_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parity: generate for what we drove, check read data one clock later

    logic par_ff, nxt_par, par_oe_ff, nxt_par_oe;
    logic chk_ff, nxt_chk, exp_ff, nxt_exp;
    logic perr_ff, nxt_perr, err_ff, nxt_err;

    always_comb begin
        nxt_par    = pci_host_pkg::even_par(ad_ff, cbe_ff); // [R12] [R13]
        nxt_par_oe = ad_oe_ff; // [R14]
        nxt_chk    = xfer && !write_ff;
        nxt_exp    = pci_host_pkg::even_par(ad_i, cbe_ff); // [R12]
        nxt_err    = chk_ff && (par_i != exp_ff); // [R13] [R14]
        nxt_perr   = (perr_n_i == pci_host_pkg::SIG_ON); // [R15]
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            par_ff    <= 1'b0;
            par_oe_ff <= 1'b0; // [R24]
            chk_ff    <= 1'b0;
            exp_ff    <= 1'b0;
            err_ff    <= 1'b0;
            perr_ff   <= 1'b0;
        end else begin
            par_ff    <= nxt_par;
            par_oe_ff <= nxt_par_oe;
            chk_ff    <= nxt_chk;
            exp_ff    <= nxt_exp;
            err_ff    <= nxt_err;
            perr_ff   <= nxt_perr;
        end
    end

    assign frame_n_o    = frame_ff;
    assign frame_n_oe   = frame_oe_ff;
    assign irdy_n_o     = irdy_ff;
    assign irdy_n_oe    = irdy_oe_ff;
    assign ad_o         = ad_ff;
    assign ad_oe        = ad_oe_ff;
    assign cbe_o        = cbe_ff;
    assign cbe_oe       = cbe_oe_ff;
    assign par_o        = par_ff;
    assign par_oe       = par_oe_ff;
    assign rd_valid     = rd_valid_ff;
    assign rd_data      = rd_data_ff;
    assign done         = done_ff;
    assign master_abort = abort_ff;
    assign par_err      = err_ff;
    assign perr_seen    = perr_ff;

endmodule

`default_nettype wire

// ### verilog/pci_host_pkg.sv
/*
 * Shared constants, state type and parity helper for the bus initiator
 * that drives the network controller through its expansion-bus pins.
 * Assumes the bus clock is sys_clk itself, so all pins share one domain.
 */
`default_nettype none

package pci_host_pkg;

    localparam int AD_W       = 32;
    localparam int CBE_W      = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int LEN_W      = 8;
    localparam int CNT_W      = 3;

    // Inactive level of every active-low bus line
    localparam logic SIG_OFF  = 1'b1;
    localparam logic SIG_ON   = 1'b0;

    // Clocks allowed for a target to claim the address
    localparam logic [CNT_W-1:0] DEVSEL_LIMIT = 3'h6;
    localparam logic [CNT_W-1:0] CNT_START    = 3'h1;
    localparam logic [LEN_W-1:0] LEN_ONE      = 8'h01;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_TURN
    } state_t;

    // Even parity: the extra bit makes the ones count even
    function automatic logic even_par(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
        even_par = ^{ad, cbe};
    endfunction

endpackage

`default_nettype wire

// ### verilog/wr_fifo.sv
/*
 * Synchronous FIFO, flip-flop storage, valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module wr_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]   cnt_ff, nxt_cnt;
    logic          push, pop;

    assign in_ready  = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        nxt_wr  = wr_ff;
        nxt_rd  = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset; cnt_ff guards every read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

endmodule

`default_nettype wire
